/* hdl/ssd_core.sv */
// Serial status, data and match register block with APB slave
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R01: As master with fault detection on, a low slave select sets the mode fault flag.
// R02: Fault detection applies only with master 1, fault enable 1, select output 0.
// R03: Mode fault clears after a read showing it set followed by a control one write.
// R04: Reserved status bits read as zero and ignore writes.
// R05: Data writes load the transmit buffer; data reads return the receive buffer.
// R06: In master mode a queued byte starts as soon as the previous transfer ends.
// R07: A data write counts only after a status read that saw transmit empty set.
// R08: Software reads received data after receive full and before the next end.
// R09: A byte finishing while the receive buffer is full is dropped silently.
// R10: The data register sits at index 5 and resets to zero.
// R11: Each byte entering the receive buffer is compared with the match value.
// R12: The match value sits at index 7 and resets to zero.
// R13: Match flag sets with receive full on equality; cleared by read as 1 then write 1.
// R14: Transmit empty sets when the buffer moves to the shifter, within two cycles idle.
// R15: A mode fault clears master, frees all outputs and aborts to idle.
// R16: A mode fault with interrupt enable set requests an interrupt.
module ssd_core
   import ssd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic miso_i,
   input wire logic ss_n_i,
   output logic sck_o,
   output logic sck_oe,
   output logic mosi_o,
   output logic mosi_oe,
   output logic miso_o,
   output logic miso_oe,
   output logic ss_n_o,
   output logic ss_n_oe,
   output logic irq
);

   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] tx_buf;
      logic [7:0] rx_buf;
      logic [7:0] cmp;
      logic [7:0] shreg;
      logic din_latch;
      logic tx_empty;
      logic rx_full;
      logic match;
      logic fault;
      logic tx_armed;
      logic fault_armed;
      logic match_armed;
      logic [3:0] ev_st;
      logic [3:0] ev_en;
      ssd_phase_e phase;
      logic [3:0] bit_cnt;
      logic [7:0] div_cnt;
      logic sck_int;
      logic sck_prev;
      logic [31:0] rdata;
   } ssd_state_s;

   ssd_state_s st;
   ssd_state_s next_st;

   logic [2:0] pin_sync;
   logic sck_s;
   logic din_s;
   logic ss_n_s;
   logic is_master;
   logic fault_watch;
   logic rd_acc;
   logic wr_acc;
   logic [7:0] widx;
   logic [3:0] ev_now;
   logic [7:0] stat_val;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [7:0] word_index(input logic [11:0] a);
      word_index = a[9:2];
   endfunction

   function automatic logic hits(input logic [11:0] a,
                                 input logic [7:0] idx);
      hits = (word_index(a) == idx) && (a[1:0] == 2'b00)
             && (a[11:10] == 2'b00);
   endfunction

   // -----------------------------------------------------------------
   // Link input synchronisation
   // -----------------------------------------------------------------
   ssd_sync #(
      .WIDTH(3)
   ) u_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .async_in({sck_i, (st.ctrl1[SSD_C1_MASTER] ? miso_i : mosi_i),
                 ss_n_i}),
      .reset_level(3'b001),
      .sync_out(pin_sync)
   );
   assign sck_s = pin_sync[2];
   assign din_s = pin_sync[1];
   assign ss_n_s = pin_sync[0];

   // -----------------------------------------------------------------
   // Mode decode and bus strobes
   // -----------------------------------------------------------------
   assign is_master = st.ctrl1[SSD_C1_MASTER];
   assign fault_watch = is_master && st.ctrl2[SSD_C2_FAULT_EN]
                        && !st.ctrl1[SSD_C1_SS_OE]; // R02
   assign rd_acc = psel && penable && !pwrite;
   assign wr_acc = psel && penable && pwrite;
   assign widx = word_index(paddr);

   // -----------------------------------------------------------------
   // Status register view
   // -----------------------------------------------------------------
   always_comb begin
      stat_val = SSD_RST_BYTE; // R04
      stat_val[SSD_ST_RX_FULL] = st.rx_full;
      stat_val[SSD_ST_MATCH] = st.match;
      stat_val[SSD_ST_TX_EMPTY] = st.tx_empty;
      stat_val[SSD_ST_FAULT] = st.fault;
   end

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   always_comb begin
      logic rx_done;
      logic sck_rise;
      logic sck_fall;
      logic ss_fault;
      logic [7:0] rx_byte;
      rx_done = 1'b0;
      sck_rise = 1'b0;
      sck_fall = 1'b0;
      ss_fault = 1'b0;
      rx_byte = st.shreg;
      ev_now = SSD_RST_EV;
      next_st = st;
      next_st.sck_prev = sck_s;

      // -----------------------------------------------------------
      // Bus read data and read side effects
      // -----------------------------------------------------------
      next_st.rdata = '0;
      if (psel && !penable && !pwrite) begin
         if (hits(paddr, SSD_IDX_CTRL1)) begin
            next_st.rdata = {24'h000000, st.ctrl1};
         end else if (hits(paddr, SSD_IDX_CTRL2)) begin
            next_st.rdata = {24'h000000, st.ctrl2};
         end else if (hits(paddr, SSD_IDX_STAT)) begin
            next_st.rdata = {24'h000000, stat_val};
         end else if (hits(paddr, SSD_IDX_DATA)) begin
            next_st.rdata = {24'h000000, st.rx_buf}; // R05
         end else if (hits(paddr, SSD_IDX_MATCH)) begin
            next_st.rdata = {24'h000000, st.cmp};
         end else if (hits(paddr, SSD_IDX_IRQ_ST)) begin
            next_st.rdata = {28'h0000000, st.ev_st};
         end else if (hits(paddr, SSD_IDX_IRQ_EN)) begin
            next_st.rdata = {28'h0000000, st.ev_en};
         end
      end
      if (rd_acc && hits(paddr, SSD_IDX_STAT)) begin
         next_st.tx_armed = st.tx_empty; // R07
         next_st.fault_armed = st.fault; // R03
         next_st.match_armed = st.match; // R13
      end
      if (rd_acc && hits(paddr, SSD_IDX_DATA)) begin
         next_st.rx_full = 1'b0;
      end

      // -----------------------------------------------------------
      // Bus writes
      // -----------------------------------------------------------
      if (wr_acc && pstrb[0]) begin
         if (hits(paddr, SSD_IDX_CTRL1)) begin
            next_st.ctrl1 = pwdata[7:0];
            if (st.fault_armed) begin
               next_st.fault = 1'b0; // R03
               next_st.fault_armed = 1'b0;
            end
         end else if (hits(paddr, SSD_IDX_CTRL2)) begin
            next_st.ctrl2 = pwdata[7:0];
         end else if (hits(paddr, SSD_IDX_STAT)) begin
            if (st.match_armed && pwdata[SSD_ST_MATCH]) begin
               next_st.match = 1'b0; // R13
               next_st.match_armed = 1'b0;
            end
         end else if (hits(paddr, SSD_IDX_DATA)) begin // R10
            if (st.tx_armed) begin // R07
               next_st.tx_buf = pwdata[7:0]; // R05
               next_st.tx_empty = 1'b0;
               next_st.tx_armed = 1'b0;
            end
         end else if (hits(paddr, SSD_IDX_MATCH)) begin
            next_st.cmp = pwdata[7:0]; // R12
         end else if (hits(paddr, SSD_IDX_IRQ_EN)) begin
            next_st.ev_en = pwdata[SSD_NUM_EV-1:0];
         end else if (hits(paddr, SSD_IDX_IRQ_CLR)) begin
            next_st.ev_st = st.ev_st & ~pwdata[SSD_NUM_EV-1:0];
         end
      end

      // -----------------------------------------------------------
      // Shifter: master makes the clock, slave follows the pin
      // -----------------------------------------------------------
      if (st.phase == SSD_IDLE) begin
         next_st.bit_cnt = SSD_BIT_ZERO;
         next_st.sck_int = 1'b0;
         next_st.div_cnt = '0;
         if (!st.tx_empty && st.ctrl1[SSD_C1_ENABLE]
             && (is_master || !ss_n_s)) begin
            next_st.phase = SSD_LOAD; // R06
         end
      end else if (st.phase == SSD_LOAD) begin
         next_st.shreg = st.tx_buf;
         next_st.tx_empty = 1'b1; // R14
         ev_now[SSD_EV_TX] = 1'b1;
         next_st.phase = SSD_SHIFT;
      end else begin
         if (is_master) begin
            if (st.div_cnt == SSD_HALF_SCK_CYC - 8'h01) begin
               next_st.div_cnt = '0;
               next_st.sck_int = !st.sck_int;
               sck_rise = !st.sck_int;
               sck_fall = st.sck_int;
            end else begin
               next_st.div_cnt = st.div_cnt + 8'h01;
            end
         end else begin
            sck_rise = sck_s && !st.sck_prev;
            sck_fall = !sck_s && st.sck_prev;
            if (ss_n_s) begin
               next_st.phase = SSD_IDLE;
            end
         end
         // Sample on rising edge, shift out on falling edge
         if (sck_rise) begin
            next_st.din_latch = din_s;
            next_st.bit_cnt = st.bit_cnt + 4'h1;
         end
         if (sck_fall) begin
            next_st.shreg = {st.shreg[6:0], st.din_latch};
            rx_byte = {st.shreg[6:0], st.din_latch};
            if (st.bit_cnt == SSD_BITS_PER_BYTE) begin
               rx_done = 1'b1;
               next_st.phase = SSD_IDLE;
            end
         end
      end

      // -----------------------------------------------------------
      // Receive completion
      // -----------------------------------------------------------
      if (rx_done) begin
         if (!st.rx_full) begin // R09
            next_st.rx_buf = rx_byte;
            next_st.rx_full = 1'b1;
            ev_now[SSD_EV_RX] = 1'b1;
            if (rx_byte == st.cmp) begin
               next_st.match = 1'b1; // R11 R13
               ev_now[SSD_EV_MATCH] = 1'b1;
            end
         end
      end

      // -----------------------------------------------------------
      // Mode fault detection and its effects
      // -----------------------------------------------------------
      ss_fault = fault_watch && !ss_n_s; // R01
      if (ss_fault) begin
         next_st.fault = 1'b1; // R01
         ev_now[SSD_EV_FAULT] = 1'b1;
         next_st.ctrl1[SSD_C1_MASTER] = 1'b0; // R15
         next_st.phase = SSD_IDLE; // R15
         next_st.sck_int = 1'b0;
         next_st.bit_cnt = SSD_BIT_ZERO;
      end

      // -----------------------------------------------------------
      // Sticky event bits: set wins over clear
      // -----------------------------------------------------------
      next_st.ev_st = next_st.ev_st | ev_now;
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st <= '0;
         st.ctrl1 <= SSD_RST_C1;
         st.tx_empty <= 1'b1;
         st.phase <= SSD_IDLE;
         st.sck_prev <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign prdata = st.rdata;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign sck_o = st.sck_int ^ 1'b0;
   assign sck_oe = is_master && st.ctrl1[SSD_C1_ENABLE]; // R15
   assign mosi_o = st.shreg[7];
   assign mosi_oe = is_master && st.ctrl1[SSD_C1_ENABLE]; // R15
   assign miso_o = st.shreg[7];
   assign miso_oe = !is_master && st.ctrl1[SSD_C1_ENABLE] && !ss_n_s
                    && !st.fault; // R15
   assign ss_n_o = !(st.phase != SSD_IDLE);
   assign ss_n_oe = is_master && st.ctrl2[SSD_C2_FAULT_EN]
                    && st.ctrl1[SSD_C1_SS_OE];
   assign irq = (|(st.ev_st & st.ev_en))
                || (st.fault && st.ctrl1[SSD_C1_IRQ_EN]); // R16

   // -----------------------------------------------------------------
   // Unused bus bits
   // -----------------------------------------------------------------
   logic unused_bits;
   assign unused_bits = ^{pwdata[31:8], pstrb[3:1], widx};

endmodule // ssd_core
`default_nettype wire

/* hdl/ssd_pkg.sv */
// Package of constants and types for the serial status/data/match block
package ssd_pkg;

   // -----------------------------------------------------------------
   // Register indices and byte addresses
   // -----------------------------------------------------------------
   localparam logic [7:0] SSD_IDX_CTRL1 = 8'h00;
   localparam logic [7:0] SSD_IDX_CTRL2 = 8'h01;
   localparam logic [7:0] SSD_IDX_STAT = 8'h03;
   localparam logic [7:0] SSD_IDX_DATA = 8'h05;
   localparam logic [7:0] SSD_IDX_MATCH = 8'h07;
   localparam logic [7:0] SSD_IDX_IRQ_ST = 8'h08;
   localparam logic [7:0] SSD_IDX_IRQ_EN = 8'h09;
   localparam logic [7:0] SSD_IDX_IRQ_CLR = 8'h0a;
   localparam logic [9:0] SSD_WORD_SHIFT = 10'h002;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int SSD_C1_IRQ_EN = 7;
   localparam int SSD_C1_ENABLE = 6;
   localparam int SSD_C1_MASTER = 4;
   localparam int SSD_C1_SS_OE = 1;
   localparam int SSD_C2_FAULT_EN = 4;
   localparam int SSD_ST_RX_FULL = 7;
   localparam int SSD_ST_MATCH = 6;
   localparam int SSD_ST_TX_EMPTY = 5;
   localparam int SSD_ST_FAULT = 4;
   localparam int SSD_EV_RX = 0;
   localparam int SSD_EV_MATCH = 1;
   localparam int SSD_EV_FAULT = 2;
   localparam int SSD_EV_TX = 3;
   localparam int SSD_NUM_EV = 4;

   // -----------------------------------------------------------------
   // Reset values and widths
   // -----------------------------------------------------------------
   localparam logic [7:0] SSD_RST_BYTE = 8'h00;
   localparam logic [7:0] SSD_RST_C1 = 8'h04;
   localparam logic [3:0] SSD_RST_EV = 4'h0;
   localparam logic [3:0] SSD_BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] SSD_BIT_ZERO = 4'h0;

   // -----------------------------------------------------------------
   // Link timing: system clock period and link half period
   // -----------------------------------------------------------------
   localparam int SSD_CLK_NS = 10;
   localparam int SSD_HALF_SCK_NS = 80;
   localparam int SSD_HALF_SCK_CYC_I =
      (SSD_HALF_SCK_NS + SSD_CLK_NS - 1) / SSD_CLK_NS;
   localparam logic [7:0] SSD_HALF_SCK_CYC = SSD_HALF_SCK_CYC_I[7:0];

   typedef enum logic [1:0] {
      SSD_IDLE,
      SSD_LOAD,
      SSD_SHIFT
   } ssd_phase_e;

   // Serial pin group
   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic mosi_o;
      logic mosi_oe;
      logic ss_o;
      logic ss_oe;
   } ssd_pins_s;

   // APB request group
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ssd_apb_req_s;

endpackage : ssd_pkg

/* hdl/ssd_sync.sv */
// Three-stage synchroniser with agreement filter for link inputs
`timescale 1ns/1ps
`default_nettype none
module ssd_sync
   import ssd_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   input wire logic [WIDTH-1:0] reset_level,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] held;
   } ssd_sync_s;

   ssd_sync_s st;
   ssd_sync_s next_st;

   // -----------------------------------------------------------------
   // Level accepted once stages two and three agree
   // -----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.held[i] = st.s3[i];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st.s1 <= reset_level;
         st.s2 <= reset_level;
         st.s3 <= reset_level;
         st.held <= reset_level;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.held;

endmodule // ssd_sync
`default_nettype wire

/* verif/ssd_core_assertions.sv */
// Port-level checker for the serial status, data and match block
`timescale 1ns/1ps
`default_nettype none
module ssd_core_assertions
   import ssd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic miso_i,
   input wire logic ss_n_i,
   input wire logic sck_o,
   input wire logic sck_oe,
   input wire logic mosi_o,
   input wire logic mosi_oe,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic ss_n_o,
   input wire logic ss_n_oe,
   input wire logic irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   property p_ready;
      psel && penable |-> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("access not answered");
   property p_noerr;
      psel && penable |-> !pslverr;
   endproperty
   a_noerr: assert property (p_noerr) else $error("error response");
   property p_idle_zero;
      !psel |-> prdata == 32'h0;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("read data idle");
   property p_upper;
      psel && penable |-> prdata[31:8] == 24'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_rsvd;
      psel && penable && !pwrite && paddr[9:2] == SSD_IDX_STAT
         |-> prdata[3:0] == 4'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_half;
      sck_oe && $changed(sck_o) |=> (!sck_oe || $stable(sck_o)) [*7];
   endproperty
   a_half: assert property (p_half) else $error("clock half short");
   property p_miso;
      sck_oe |-> !miso_oe;
   endproperty
   a_miso: assert property (p_miso) else $error("master drives miso");
   property p_oe;
      sck_oe == mosi_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("outputs not freed together");
   property p_irq_rst;
      $fell(sys_rst) |-> !irq;
   endproperty
   a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
   c_write: cover property (psel && penable && pwrite);
   c_irq: cover property ($rose(irq));
   c_fault: cover property ($fell(sck_oe));
endmodule // ssd_core_assertions
bind ssd_core ssd_core_assertions u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sck_i(sck_i), .mosi_i(mosi_i), .miso_i(miso_i),
   .ss_n_i(ss_n_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_o(mosi_o),
   .mosi_oe(mosi_oe), .miso_o(miso_o), .miso_oe(miso_oe),
   .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .irq(irq));
`default_nettype wire

/* verif/ssd_slave_model.sv */
// Behavioural mode 0 serial slave; sends reply, then its inverse
`timescale 1ns/1ps
`default_nettype none
module ssd_slave_model (
   input wire logic sck,
   input wire logic sck_oe,
   input wire logic mosi,
   input wire logic [7:0] reply,
   output logic miso,
   output logic [7:0] got
);
   logic [7:0] rx = 8'h00;
   logic [7:0] cur = 8'h00;
   logic [2:0] cnt = 3'h0;
   logic flip = 1'b0;
   logic bit_o = 1'b0;
   always @(posedge sck) begin
      rx <= {rx[6:0], mosi};
      if (cnt == 3'h0) begin
         cur <= flip ? ~reply : reply;
      end
      if (cnt == 3'h7) begin
         got <= {rx[6:0], mosi};
         flip <= ~flip;
      end
      cnt <= cnt + 3'h1;
   end
   // Next bit moves out on the falling edge
   always @(negedge sck) begin
      if (cnt != 3'h0) begin
         bit_o <= cur[3'h7 - cnt];
      end
   end
   // Released clock: line shows the inverse of the last bit
   assign miso = !sck_oe ? ~bit_o :
      (cnt == 3'h0) ? (flip ? ~reply[7] : reply[7]) : bit_o;
endmodule // ssd_slave_model
`default_nettype wire

/* verif/ssd_core_tb.sv */
// Self-checking bench for the serial status, data and match block
`timescale 1ns/1ps
`default_nettype none
module ssd_core_tb
   import ssd_pkg::*;
();
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ss_n_i = 1'b1;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'h0;
   logic pready, pslverr, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
   logic ss_n_o, ss_n_oe, irq, miso_i;
   logic [7:0] reply = 8'ha5, got;
   int fails = 0, samples_checked = 0;
   wire logic sck_i = sck_oe ? sck_o : 1'b0;
   wire logic mosi_i = mosi_oe ? mosi_o : 1'b0;
   always #5 clk_sys = ~clk_sys;
   ssd_core dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sck_i(sck_i), .mosi_i(mosi_i), .miso_i(miso_i), .ss_n_i(ss_n_i),
      .sck_o(sck_o), .sck_oe(sck_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
      .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_o(ss_n_o),
      .ss_n_oe(ss_n_oe), .irq(irq));
   ssd_slave_model peer (.sck(sck_o), .sck_oe(sck_oe), .mosi(mosi_o),
      .reply(reply), .miso(miso_i), .got(got));

   task automatic chk(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results();
      $display("Checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // APB transfer; entered and left just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [7:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, wd};
      pstrb <= 4'h1;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk_sys);
      end
      chk("apb ready", pready, 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rdc(input string name, input logic [7:0] idx,
      input logic [31:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(name, rd, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic t_gate();
      apb(1'b1, SSD_IDX_CTRL1, 8'h50);
      apb(1'b1, SSD_IDX_DATA, 8'h3c);
      cyc(300);
      rdc("status gated", SSD_IDX_STAT, 32'h20);
   endtask
   task automatic t_reset();
      rdc("data reset", SSD_IDX_DATA, 32'h0);
      rdc("match reset", SSD_IDX_MATCH, 32'h0);
      rdc("unmapped", 8'h0b, 32'h0);
      chk("irq reset", irq, 1'b0);
   endtask
   task automatic t_xfer();
      int n;
      n = 0;
      apb(1'b1, SSD_IDX_MATCH, 8'ha5);
      rdc("match rw", SSD_IDX_MATCH, 32'ha5);
      rdc("status arm", SSD_IDX_STAT, 32'h20);
      apb(1'b1, SSD_IDX_DATA, 8'h3c);
      cyc(1);
      rdc("empty fast", SSD_IDX_STAT, 32'h20);
      apb(1'b1, SSD_IDX_DATA, 8'h77);
      rdc("queued", SSD_IDX_STAT, 32'h00);
      rd = 32'h0;
      while (rd[7] !== 1'b1 && n < 200) begin
         n++;
         apb(1'b0, SSD_IDX_STAT, 8'h00);
      end
      cyc(4);
      rdc("first done", SSD_IDX_STAT, 32'he0);
      chk("first sent", got, 8'h3c);
      n = 0;
      while (got !== 8'h77 && n < 400) begin
         n++;
         cyc(1);
      end
      chk("queued sent", got, 8'h77);
      cyc(20);
      rdc("overrun keeps", SSD_IDX_DATA, 32'ha5);
      rdc("no rx after", SSD_IDX_STAT, 32'h60);
      apb(1'b1, SSD_IDX_STAT, 8'h40);
      rdc("match clear", SSD_IDX_STAT, 32'h20);
      apb(1'b1, SSD_IDX_IRQ_EN, 8'h01);
      #2 chk("irq on", irq, 1'b1);
      @(posedge clk_sys);
      apb(1'b1, SSD_IDX_IRQ_EN, 8'h00);
      #2 chk("irq masked", irq, 1'b0);
      @(posedge clk_sys);
      apb(1'b0, SSD_IDX_IRQ_ST, 8'h00);
      chk("events", rd & 32'h7, 32'h3);
      apb(1'b1, SSD_IDX_IRQ_CLR, 8'h0f);
      apb(1'b1, SSD_IDX_IRQ_EN, 8'h01);
      rdc("events clear", SSD_IDX_IRQ_ST, 32'h0);
      chk("irq cleared", irq, 1'b0);
   endtask
   task automatic t_fault();
      logic [15:0] cfg [3];
      cfg = '{16'h5000, 16'h5210, 16'h4010};
      foreach (cfg[i]) begin
         apb(1'b1, SSD_IDX_CTRL2, cfg[i][7:0]);
         apb(1'b1, SSD_IDX_CTRL1, cfg[i][15:8]);
         ss_n_i <= 1'b0;
         cyc(12);
         rdc("no fault", SSD_IDX_STAT, 32'h20);
         ss_n_i <= 1'b1;
         cyc(12);
      end
      apb(1'b1, SSD_IDX_CTRL2, 8'h10);
      apb(1'b1, SSD_IDX_CTRL1, 8'hd0);
      ss_n_i <= 1'b0;
      cyc(12);
      chk("fault irq", irq, 1'b1);
      chk("outputs free", {sck_oe, mosi_oe, miso_oe}, 3'h0);
      rdc("master off", SSD_IDX_CTRL1, 32'hc0);
      ss_n_i <= 1'b1;
      cyc(12);
      apb(1'b1, SSD_IDX_CTRL1, 8'hc0);
      rdc("fault held", SSD_IDX_STAT, 32'h30);
      apb(1'b1, SSD_IDX_CTRL1, 8'h40);
      rdc("fault clear", SSD_IDX_STAT, 32'h20);
   endtask

   initial begin
      cyc(2);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      t_gate();
      t_reset();
      t_xfer();
      t_fault();
      results();
   end
   initial begin
      #100000;
      fails++;
      results();
   end
endmodule // ssd_core_tb
`default_nettype wire
